// *** rtl/nand_host_pkg.sv ***
// constants for the flash pin controller
package nand_host_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int READ_CYCLE_NS = 25;
  localparam int READ_CYCLE_CYC = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_LOW_CYC = (READ_CYCLE_CYC + 1) / 2;
  localparam int STROBE_HIGH_CYC = READ_CYCLE_CYC - STROBE_LOW_CYC;
  localparam int FETCH_US = 200;
  localparam int FETCH_CYC = FETCH_US * 1000 / CLK_PERIOD_NS;
  localparam int STANDBY_US = 10;
  localparam int STANDBY_CYC = STANDBY_US * 1000 / CLK_PERIOD_NS;
  localparam int PROGRAM_US = 1600;
  localparam int PROGRAM_CYC = PROGRAM_US * 1000 / CLK_PERIOD_NS;
  localparam int ERASE_US = 2500;
  localparam int ERASE_CYC = ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam int MAIN_BYTES = 8192;
  localparam int SPARE_BYTES = 448;
  localparam int PAGE_BYTES = MAIN_BYTES + SPARE_BYTES;
  localparam int PAGES_PER_BLOCK = 256;
  localparam int BLOCKS_PER_PLANE = 512;
  localparam int PLANES = 2;
  localparam int COL_LSB = 0;
  localparam int COL_BITS = 14;
  localparam int PAGE_LSB = 14;
  localparam int PAGE_BITS = 8;
  localparam int PLANE_LSB = 22;
  localparam int BLOCK_LSB = 23;
  localparam int BLOCK_BITS = 9;
  localparam int ADDR_CYCLES = 5;
  localparam int FIFO_DEPTH = 4;
  localparam logic [1:0] KIND_CMD = 2'h0;
  localparam logic [1:0] KIND_ADDR = 2'h1;
  localparam logic [1:0] KIND_WRITE = 2'h2;
  localparam logic [1:0] KIND_READ = 2'h3;
endpackage

// *** rtl/byte_fifo.sv ***
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_mem
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        mem_q[i] <= '0;
      end else if (push && wr_q == AW'(i)) begin
        mem_q[i] <= in_data;
      end
    end
  end

  fifo_no_overflow_a: assert property (@(posedge clk) disable iff (rst)
    cnt_q <= (AW+1)'(DEPTH)) else $error("fifo accepts while full");
endmodule

// *** rtl/nand_host.sv ***
// host controller driving the flash pins: command, address, write and read cycles
`timescale 1ns/1ps
module nand_host
  import nand_host_pkg::*;
#(
  parameter int FETCH_CYCLES = FETCH_CYC,
  parameter int STANDBY_CYCLES = STANDBY_CYC,
  parameter int WAIT_LIMIT = ERASE_CYC * 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [1:0] req_kind,
  input wire logic [7:0] req_byte,
  input wire logic req_wait_busy,
  input wire logic req_fetch,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  output logic busy_seen,
  output logic idle,
  input wire logic protect,
  output logic cmd_latch,
  output logic addr_latch,
  output logic chip_sel_n,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic write_protect_n,
  input wire logic [7:0] io_bus_i,
  output logic [7:0] io_bus_o,
  output logic io_bus_oe,
  input wire logic ready_busy_n_i,
  output logic wait_timeout
);
  typedef enum {ST_IDLE, ST_WR_LOW, ST_WR_HIGH, ST_RD_LOW, ST_RD_HIGH, ST_WAIT, ST_FETCH} state_t;
  state_t st_q, st_d, after_q, after_d;
  logic [5:0] tim_q, tim_d;
  logic [31:0] wait_q, wait_d;
  logic [31:0] idle_cnt_q, idle_cnt_d;
  logic cle_q, cle_d, ale_q, ale_d, ce_n_q, ce_n_d, we_n_q, we_n_d, re_n_q, re_n_d;
  logic oe_q, oe_d, wp_n_q, wp_n_d, tout_q, tout_d;
  logic [7:0] dout_q, dout_d;
  logic [7:0] cap_q, cap_d;
  logic cap_v_q, cap_v_d;
  logic rb1_q, rb2_q, rb3_q, rb_q, rb_d;
  logic fifo_in_ready;

  // ready/busy passes three flops; change accepted when second and third agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rb1_q <= 1'b1;
      rb2_q <= 1'b1;
      rb3_q <= 1'b1;
      rb_q <= 1'b1;
    end else begin
      rb1_q <= ready_busy_n_i;
      rb2_q <= rb1_q;
      rb3_q <= rb2_q;
      rb_q <= rb_d;
    end
  end
  always_comb begin
    rb_d = (rb2_q == rb3_q) ? rb3_q : rb_q;
  end

  assign req_ready = (st_q == ST_IDLE) && !cap_v_q && !ce_n_q &&
                     !(req_kind == KIND_READ && !fifo_in_ready);
  assign busy_seen = !rb_q;
  assign idle = (st_q == ST_IDLE);
  assign cmd_latch = cle_q;
  assign addr_latch = ale_q;
  assign chip_sel_n = ce_n_q;
  assign write_strobe_n = we_n_q;
  assign read_strobe_n = re_n_q;
  assign write_protect_n = wp_n_q;
  assign io_bus_o = dout_q;
  assign io_bus_oe = oe_q;
  assign wait_timeout = tout_q;

  always_comb begin
    st_d = st_q;
    after_d = after_q;
    tim_d = tim_q;
    wait_d = wait_q;
    idle_cnt_d = idle_cnt_q;
    cle_d = cle_q;
    ale_d = ale_q;
    ce_n_d = ce_n_q;
    we_n_d = we_n_q;
    re_n_d = re_n_q;
    oe_d = oe_q;
    dout_d = dout_q;
    cap_d = cap_q;
    cap_v_d = cap_v_q && !fifo_in_ready;
    tout_d = 1'b0;
    // protect driven as a level every cycle
    wp_n_d = !protect;
    case (st_q)
      ST_IDLE: begin
        cle_d = 1'b0;
        ale_d = 1'b0;
        oe_d = 1'b0;
        // release chip select after a long idle while ready
        if (rb_q && idle_cnt_q < 32'(STANDBY_CYCLES)) begin
          idle_cnt_d = idle_cnt_q + 32'd1;
        end else if (rb_q) begin
          ce_n_d = 1'b1;
        end
        // wake from standby a cycle before any strobe moves
        if (req_valid) begin
          ce_n_d = 1'b0;
        end
        if (req_valid && req_ready) begin
          idle_cnt_d = '0;
          ce_n_d = 1'b0;
          tim_d = 6'(STROBE_LOW_CYC);
          if (req_kind == KIND_READ) begin
            st_d = ST_RD_LOW;
            re_n_d = 1'b0;
          end else begin
            // command latch high for command bytes
            cle_d = (req_kind == KIND_CMD);
            // address latch high, address bytes passed in cycle order
            ale_d = (req_kind == KIND_ADDR);
            dout_d = req_byte;
            oe_d = 1'b1;
            we_n_d = 1'b0;
            st_d = ST_WR_LOW;
            after_d = req_fetch ? ST_FETCH : (req_wait_busy ? ST_WAIT : ST_IDLE);
          end
        end
      end
      ST_WR_LOW: begin
        tim_d = tim_q - 6'd1;
        if (tim_q == 6'd1) begin
          // rising write strobe with byte still stable
          we_n_d = 1'b1;
          tim_d = 6'(STROBE_HIGH_CYC);
          st_d = ST_WR_HIGH;
        end
      end
      ST_WR_HIGH: begin
        tim_d = tim_q - 6'd1;
        if (tim_q == 6'd1) begin
          cle_d = 1'b0;
          ale_d = 1'b0;
          oe_d = 1'b0;
          wait_d = '0;
          st_d = after_q;
        end
      end
      ST_RD_LOW: begin
        tim_d = tim_q - 6'd1;
        if (tim_q == 6'd1) begin
          // sample device data before strobe rises
          cap_d = io_bus_i;
          cap_v_d = 1'b1;
          re_n_d = 1'b1;
          tim_d = 6'(STROBE_HIGH_CYC);
          st_d = ST_RD_HIGH;
        end
      end
      ST_RD_HIGH: begin
        tim_d = tim_q - 6'd1;
        // full read cycle kept at least 25ns
        if (tim_q == 6'd1) begin
          st_d = ST_IDLE;
        end
      end
      ST_FETCH: begin
        // allow the page fetch time before reading
        wait_d = wait_q + 32'd1;
        if (wait_q >= 32'(FETCH_CYCLES) - 32'd1) begin
          wait_d = '0;
          st_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // chip select held low while device is busy
        ce_n_d = 1'b0;
        wait_d = wait_q + 32'd1;
        if (rb_q && wait_q > 32'd8) begin
          st_d = ST_IDLE;
        end else if (wait_q >= 32'(WAIT_LIMIT)) begin
          tout_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      after_q <= ST_IDLE;
      tim_q <= '0;
      wait_q <= '0;
      idle_cnt_q <= '0;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      ce_n_q <= 1'b1;
      we_n_q <= 1'b1;
      re_n_q <= 1'b1;
      oe_q <= 1'b0;
      dout_q <= '0;
      cap_q <= '0;
      cap_v_q <= 1'b0;
      wp_n_q <= 1'b0;
      tout_q <= 1'b0;
    end else begin
      st_q <= st_d;
      after_q <= after_d;
      tim_q <= tim_d;
      wait_q <= wait_d;
      idle_cnt_q <= idle_cnt_d;
      cle_q <= cle_d;
      ale_q <= ale_d;
      ce_n_q <= ce_n_d;
      we_n_q <= we_n_d;
      re_n_q <= re_n_d;
      oe_q <= oe_d;
      dout_q <= dout_d;
      cap_q <= cap_d;
      cap_v_q <= cap_v_d;
      wp_n_q <= wp_n_d;
      tout_q <= tout_d;
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(cap_v_q),
    .in_ready(fifo_in_ready),
    .in_data(cap_q),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // command latch only during a write cycle with the bus driven, never with address latch or read
  cle_with_write_a: assert property (@(posedge clk) disable iff (rst)
    cmd_latch |-> !addr_latch && read_strobe_n && io_bus_oe) else $error("command latch outside write cycle");
  // address latch never together with read
  ale_no_read_a: assert property (@(posedge clk) disable iff (rst)
    addr_latch |-> read_strobe_n && io_bus_oe) else $error("address latch without drive");
  // byte stable at rising write strobe
  byte_stable_rise_a: assert property (@(posedge clk) disable iff (rst)
    $rose(write_strobe_n) |-> io_bus_oe && $stable(io_bus_o)) else $error("byte moved at strobe rise");
  no_drive_read_a: assert property (@(posedge clk) disable iff (rst)
    !read_strobe_n |-> !io_bus_oe) else $error("bus contention on read");
  // chip select stays low while waiting
  cs_low_wait_a: assert property (@(posedge clk) disable iff (rst)
    (st_q == ST_WAIT) |=> !chip_sel_n) else $error("chip select raised while busy");
  // protect follows its input in one cycle
  wp_level_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> write_protect_n == !$past(protect)) else $error("write protect not a level");
  // read strobe low for the whole low phase
  read_low_len_a: assert property (@(posedge clk) disable iff (rst)
    $fell(read_strobe_n) |-> !read_strobe_n [*4]) else $error("read strobe too short");
  busy_filter_a: assert property (@(posedge clk) disable iff (rst)
    (rb2_q == rb3_q) |=> busy_seen == !$past(rb3_q)) else $error("busy filter wrong");

  cmd_sent_c: cover property (@(posedge clk) $rose(write_strobe_n) && cmd_latch);
  addr_sent_c: cover property (@(posedge clk) $rose(write_strobe_n) && addr_latch);
  read_done_c: cover property (@(posedge clk) rd_valid && rd_ready);
  busy_wait_c: cover property (@(posedge clk) st_q == ST_WAIT && busy_seen);
endmodule

// *** sim/flash_model.sv ***
// behavioural flash device answering the host pins
`timescale 1ns/1ps
module flash_model
  import nand_host_pkg::*;
#(
  parameter logic [7:0] READ_GO = 8'h30,
  parameter logic [7:0] PROG_GO = 8'h10,
  parameter logic [7:0] ERASE_GO = 8'hD0,
  parameter int READ_NS = 80,
  parameter int PROG_NS = 400
) (
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic chip_sel_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_protect_n,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic io_oe,
  output logic rb_pull
);
  // one full page of main and spare bytes
  logic [7:0] mem [PAGE_BYTES];
  logic [7:0] page [PAGE_BYTES];
  logic [39:0] addr = '0;
  logic [13:0] col = '0;
  logic [7:0] last_cmd = 8'h00;
  logic busy = 1'b0;
  int acnt = 0;
  initial begin
    io_out = 8'h00;
    for (int i = 0; i < PAGE_BYTES; i++) begin
      mem[i] = 8'h00;
      page[i] = 8'hFF;
    end
  end
  // open drain pulled low while busy
  assign rb_pull = busy;
  assign io_oe = !chip_sel_n && !read_strobe_n;
  always @(posedge write_strobe_n) begin
    if (!chip_sel_n && !busy) begin
      if (cmd_latch) begin
        last_cmd = io_in;
        acnt = 0;
        run(io_in);
      end else if (addr_latch) begin
        // row bytes carry page, plane and block
        if (acnt < ADDR_CYCLES) addr[8*acnt +: 8] = io_in;
        acnt++;
        col = addr[13:0];
      end else begin
        page[col] = io_in;
        col++;
      end
    end
  end
  // array work, program and erase skipped while protected; read still loads the page
  task automatic run(input logic [7:0] c);
    if (c == READ_GO) begin
      busy = 1'b1;
      #(READ_NS);
      page = mem;
      busy = 1'b0;
    end else if ((c == PROG_GO || c == ERASE_GO) && write_protect_n) begin
      busy = 1'b1;
      #(PROG_NS);
      for (int i = 0; i < PAGE_BYTES; i++) begin
        mem[i] = (c == PROG_GO) ? page[i] : 8'hFF;
        page[i] = 8'hFF;
      end
      busy = 1'b0;
    end
  endtask
  // falling read strobe drives next byte
  always @(negedge read_strobe_n) begin
    if (!chip_sel_n) begin
      io_out = page[col];
      col++;
    end
  end
endmodule

// *** sim/nand_host_bench.sv ***
// testbench for the flash pin controller
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module nand_host_bench;
  import nand_host_pkg::*;
  localparam logic [7:0] READ_GO = 8'h30;
  localparam logic [7:0] PROG_GO = 8'h10;
  localparam logic [7:0] ERASE_GO = 8'hD0;
  logic clk = 0, rst = 1, req_valid = 0, req_wait_busy = 0, req_fetch = 0, rd_ready = 0, protect = 0;
  logic [1:0] req_kind = KIND_CMD;
  logic [7:0] req_byte = 8'h00, rd_data, io_bus_o, dev_out, float_q = 8'h00;
  logic req_ready, rd_valid, busy_seen, idle, cmd_latch, addr_latch, chip_sel_n, write_strobe_n;
  logic read_strobe_n, write_protect_n, io_bus_oe, wait_timeout, dev_oe, rb_pull;
  wire logic [7:0] io_bus_i;
  wire logic ready_busy_n_i;
  int err_count = 0, checks_done = 0, cycles = 0, tout_seen = 0;
  realtime last_fall = 0;
  nand_host #(.FETCH_CYCLES(20), .STANDBY_CYCLES(10), .WAIT_LIMIT(200)) u_dut (.clk, .rst, .req_valid,
    .req_ready, .req_kind, .req_byte, .req_wait_busy, .req_fetch, .rd_valid, .rd_ready, .rd_data,
    .busy_seen, .idle, .protect, .cmd_latch, .addr_latch, .chip_sel_n, .write_strobe_n, .read_strobe_n,
    .write_protect_n, .io_bus_i, .io_bus_o, .io_bus_oe, .ready_busy_n_i, .wait_timeout);
  flash_model #(.READ_GO(READ_GO), .PROG_GO(PROG_GO), .ERASE_GO(ERASE_GO)) u_dev (.cmd_latch,
    .addr_latch, .chip_sel_n, .write_strobe_n, .read_strobe_n, .write_protect_n, .io_in(io_bus_i),
    .io_out(dev_out), .io_oe(dev_oe), .rb_pull);
  assign io_bus_i = io_bus_oe ? io_bus_o : (dev_oe ? dev_out : float_q);
  assign ready_busy_n_i = !rb_pull;
  always @(posedge clk) float_q <= ~io_bus_i;
  always @(posedge clk) if (wait_timeout === 1'b1) tout_seen++;
  always #2 clk = ~clk;
  always @(negedge read_strobe_n) begin
    if (last_fall > 0) `CHK($realtime - last_fall >= 25.0, 1'b1)
    last_fall = $realtime;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic send(input logic [1:0] k, input logic [7:0] b, input logic wb = 0, input logic fe = 0);
    int n = 0;
    req_kind <= k;
    req_byte <= b;
    req_wait_busy <= wb;
    req_fetch <= fe;
    req_valid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 3000);
    req_valid <= 1'b0;
    `CHK(n < 3000, 1'b1)
    @(posedge clk);
  endtask
  task automatic wait_idle();
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (idle !== 1'b1 && n < 3000);
    `CHK(idle, 1'b1)
  endtask
  task automatic pop(input logic [7:0] exp);
    int n = 0;
    rd_ready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rd_valid !== 1'b1 && n < 100);
    rd_ready <= 1'b0;
    `CHK(rd_valid, 1'b1)
    `CHK(rd_data, exp)
    @(posedge clk);
  endtask
  task automatic address(input logic [7:0] c);
    send(KIND_CMD, c);
    send(KIND_ADDR, 8'h02);
    repeat (4) send(KIND_ADDR, 8'h00);
  endtask
  task automatic prog(input logic [7:0] d);
    address(8'h80);
    for (int i = 0; i < 3; i++) send(KIND_WRITE, d + 8'(i));
    send(KIND_CMD, PROG_GO, 1'b1);
    wait_idle();
  endtask
  task automatic t_walk();
    send(KIND_CMD, 8'h70);
    #1;
    `CHK({chip_sel_n, cmd_latch, addr_latch, io_bus_oe, write_strobe_n}, 5'h0A)
    `CHK(io_bus_o, 8'h70)
    wait_idle();
    `CHK(u_dev.last_cmd, 8'h70)
    send(KIND_ADDR, 8'h5C);
    #1;
    `CHK({cmd_latch, addr_latch, io_bus_o}, {2'h1, 8'h5C})
    wait_idle();
    $display("test walk done");
  endtask
  task automatic t_prog();
    int n = 0;
    address(8'h60);
    send(KIND_CMD, ERASE_GO, 1'b1);
    while (busy_seen !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    `CHK(busy_seen, 1'b1)
    `CHK(ready_busy_n_i, 1'b0)
    `CHK(chip_sel_n, 1'b0)
    wait_idle();
    `CHK(u_dev.mem[9], 8'hFF)
    prog(8'hA5);
    `CHK({u_dev.mem[2], u_dev.mem[4]}, 16'hA5A7)
    $display("test program done");
  endtask
  task automatic t_protect();
    protect <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    `CHK(write_protect_n, 1'b0)
    prog(8'h10);
    `CHK(u_dev.mem[3], 8'hA6)
    protect <= 1'b0;
    $display("test protect done");
  endtask
  task automatic t_read();
    int n = 0;
    address(8'h00);
    send(KIND_CMD, READ_GO, 1'b0, 1'b1);
    wait_idle();
    send(KIND_READ, 8'h00);
    `CHK({io_bus_oe, read_strobe_n}, 2'h0)
    repeat (3) send(KIND_READ, 8'h00);
    req_kind <= KIND_READ;
    req_valid <= 1'b1;
    repeat (20) begin
      @(posedge clk);
      if (req_ready === 1'b1) n++;
    end
    req_valid <= 1'b0;
    `CHK(n, 0)
    @(posedge clk);
    for (int i = 0; i < 3; i++) pop(8'hA5 + 8'(i));
    pop(8'hFF);
    send(KIND_READ, 8'h00);
    pop(8'hFF);
    $display("test read done");
  endtask
  task automatic t_standby();
    repeat (30) @(posedge clk);
    #1;
    `CHK(chip_sel_n, 1'b1)
    `CHK(tout_seen, 0)
    $display("test standby done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_walk();
    t_prog();
    t_protect();
    t_read();
    t_standby();
    complete_run();
  end
endmodule
